// file: src/asc_clkdiv.sv
`timescale 1ns/1ns
// one-cycle enable every (DIV<<shift) cycles
module asc_clkdiv #(
    parameter int DIV = 2
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // control
    input  wire logic        run_i,
    input  wire logic [1:0]  shift_i,
    output logic             tick_o
);
    logic [15:0] cnt_ff;
    logic [15:0] lim;

    assign lim = 16'((DIV << shift_i) - 1);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 16'h0000;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_ff <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_ff >= lim) begin
            cnt_ff <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : asc_clkdiv

// file: src/asc_ctrl.sv
`timescale 1ns/1ns
module asc_ctrl #(
    parameter int RES_W = 10
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [7:0]       rdata_o,
    // periodic counter control
    input  wire logic        use_ref_clk_i,
    input  wire logic [2:0]  periodic_rate_select_i,
    input  wire logic        ref_tick_i,
    // analog front end
    input  wire logic        cmp_i,
    output logic             sample_o,
    output logic [RES_W-1:0] dac_o,
    output logic [4:0]       channel_select_field_o,
    output logic [7:0]       analog_pin_enable_o,
    output logic             hw_conversion_trigger_o,
    // events
    output logic             irq_o,
    output logic             busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SMP  = 3'b010,
        ST_CONV = 3'b100
    } asc_st_t;

    asc_st_t     st_ff;
    logic [7:0]  sc1_ff;
    logic [7:0]  sc2_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  ape_ff;
    logic [9:0]  cv_ff;
    logic [9:0]  res_ff;
    logic [9:0]  sar_ff;
    logic [3:0]  bit_ff;
    logic [5:0]  smp_ff;
    logic [1:0]  cmp_sync_ff;
    logic        done_ff;
    logic        hw_pend_ff;
    logic [15:0] rti_ff;
    logic [7:0]  rdata_ff;
    logic [1:0]  stl_ff;

    // ==================================================================
    // conversion clock enable
    logic [1:0] clk_sel;
    logic       div_run;
    logic       bus2_tick;
    logic       async_tick;
    logic       conv_tick;
    logic       cmp_bit;

    assign clk_sel = cfg_ff[asc_pkg::CFG_CLKHI:asc_pkg::CFG_CLKLO];
    assign div_run = (st_ff != ST_IDLE);
    assign cmp_bit = cmp_sync_ff[1];

    asc_clkdiv #(.DIV(2)) u_bus2 (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (div_run),
        .shift_i   (cfg_ff[asc_pkg::CFG_DIVHI:asc_pkg::CFG_DIVLO]),
        .tick_o    (bus2_tick)
    );
    asc_clkdiv #(.DIV(asc_pkg::ASYNC_DIV)) u_async (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (div_run),
        .shift_i   (cfg_ff[asc_pkg::CFG_DIVHI:asc_pkg::CFG_DIVLO]),
        .tick_o    (async_tick)
    );

    // alternate clock has no source, so that selection never ticks
    always_comb begin
        case (clk_sel) // [R1] [R2]
            asc_pkg::CLK_BUS:   conv_tick = div_run;
            asc_pkg::CLK_BUS2:  conv_tick = bus2_tick;
            asc_pkg::CLK_ASYNC: conv_tick = async_tick;
            default:            conv_tick = 1'b0;
        endcase
    end

    // ==================================================================
    // periodic trigger counter
    logic       slow_tick;
    logic       rti_tick;
    logic [3:0] rti_bit;
    logic       rti_ovf;

    // slow tick stands in for the nominal 32 kHz source
    asc_clkdiv #(.DIV(asc_pkg::SLOW_DIV)) u_slow (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (1'b1),
        .shift_i   (2'h0),
        .tick_o    (slow_tick)
    );

    // counter free runs in every power mode, hence no mode gating
    assign rti_tick = use_ref_clk_i ? ref_tick_i : slow_tick; // [R4] [R6]
    assign rti_bit  = 4'({1'b0, periodic_rate_select_i} + 4'h8);
    assign rti_ovf  = rti_tick && (periodic_rate_select_i != 3'h0) &&
                      ((rti_ff & ((16'h0001 << rti_bit) - 16'h0001)) ==
                       ((16'h0001 << rti_bit) - 16'h0001));

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rti_ff                  <= 16'h0000;
            hw_conversion_trigger_o <= 1'b0;
        end else begin
            if (rti_tick) begin
                rti_ff <= rti_ff + 16'h0001; // [R5]
            end
            hw_conversion_trigger_o <= rti_ovf;
        end
    end

    // ==================================================================
    // register writes
    logic sc1_wr;
    logic rl_rd;
    logic ch_off;
    logic hw_mode;
    logic start;
    logic res_done;
    logic cmp_true;

    assign sc1_wr  = wr_i && (addr_i == asc_pkg::OFF_SC1);
    assign rl_rd   = rd_i && (addr_i == asc_pkg::OFF_RL);
    assign ch_off  = (sc1_ff[4:0] == asc_pkg::CH_OFF);
    assign hw_mode = sc2_ff[asc_pkg::SC2_HWTE];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sc1_ff <= asc_pkg::SC1_RST;
            sc2_ff <= 8'h00;
            cfg_ff <= 8'h00;
            ape_ff <= 8'h00;
            cv_ff  <= 10'h000;
        end else if (wr_i) begin
            case (addr_i) // [R17] [R8]
                asc_pkg::OFF_SC1: sc1_ff <= {1'b0, wdata_i[6:0]};
                asc_pkg::OFF_SC2: sc2_ff <= {1'b0, wdata_i[6:4], 4'h0};
                asc_pkg::OFF_CVH: cv_ff[9:8] <= wdata_i[1:0];
                asc_pkg::OFF_CVL: cv_ff[7:0] <= wdata_i;
                asc_pkg::OFF_CFG: cfg_ff <= wdata_i; // [R15]
                asc_pkg::OFF_APE: ape_ff <= wdata_i;
                default:          ;
            endcase
        end
    end

    // ==================================================================
    // completion flag: a completion in the clearing cycle wins
    logic [9:0] res_fmt;
    logic [9:0] sar_fin;
    logic       mode10;

    assign mode10   = (cfg_ff[asc_pkg::CFG_MODHI:asc_pkg::CFG_MODLO] == asc_pkg::MODE_10);
    // bit 0 is decided in the same edge that stores the result, so the
    // comparator answer goes in directly instead of the trial bit
    assign sar_fin  = {sar_ff[9:1], cmp_bit};
    assign res_fmt  = mode10 ? sar_fin : {2'b00, sar_fin[9:2]}; // [R10]
    assign cmp_true = !sc2_ff[asc_pkg::SC2_CMPE] ||
                      (sc2_ff[asc_pkg::SC2_CMPGT] ? (res_fmt >= cv_ff)
                                                 : (res_fmt < cv_ff)); // [R13]

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_ff <= 1'b0;
        end else if (res_done && cmp_true) begin
            done_ff <= 1'b1; // [R14]
        end else if (sc1_wr || rl_rd) begin
            done_ff <= 1'b0; // [R19]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_ff <= 10'h000;
        end else if (res_done && cmp_true) begin
            // a failed compare leaves the previous result in place
            res_ff <= res_fmt;
        end
    end

    // ==================================================================
    // trigger capture
    // a trigger that lands mid conversion waits here for the idle state
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_pend_ff <= 1'b0;
        end else if (sc1_wr || !hw_mode) begin
            hw_pend_ff <= 1'b0; // [R20]
        end else if (hw_conversion_trigger_o && !ch_off) begin
            hw_pend_ff <= 1'b1; // [R3]
        end else if (start) begin
            hw_pend_ff <= 1'b0;
        end
    end

    // ==================================================================
    // successive approximation sequencer
    logic [5:0] smp_len;
    logic       step;

    // long sample wins; otherwise low power stretches the short sample
    assign smp_len = cfg_ff[asc_pkg::CFG_LSMP] ? 6'(asc_pkg::SMP_LONG)
                   : (cfg_ff[asc_pkg::CFG_LPWR] ? 6'(asc_pkg::SMP_SHORT)
                                                : 6'(asc_pkg::SMP_HSP));
    assign start    = (st_ff == ST_IDLE) && hw_pend_ff;
    // one step per conversion tick, never before the settle count runs out
    assign step     = conv_tick && (stl_ff == 2'h0);
    assign res_done = (st_ff == ST_CONV) && step && (bit_ff == 4'h0);

    // ==================================================================
    // comparator settle: a new trial code passes the output register and
    // the two synchroniser stages before its answer can be read, so every
    // decision waits three cycles after the code last moved; this paces the
    // bus clock and undivided bus half settings, and the slower settings hardly notice it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stl_ff <= asc_pkg::CMP_SETTLE;
        end else if ((st_ff != ST_CONV) || step) begin
            stl_ff <= asc_pkg::CMP_SETTLE;
        end else if (stl_ff != 2'h0) begin
            stl_ff <= stl_ff - 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_sync_ff <= 2'b00;
        end else begin
            cmp_sync_ff <= {cmp_sync_ff[0], cmp_i};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff  <= ST_IDLE;
            sar_ff <= 10'h000;
            bit_ff <= 4'h0;
            smp_ff <= 6'h00;
        end else if (sc1_wr) begin
            // abort, and restart in software trigger mode only; all ones switches the converter off
            if (wdata_i[4:0] != asc_pkg::CH_OFF && !hw_mode) begin // [R18]
                st_ff  <= ST_SMP;
                smp_ff <= 6'h00;
            end else begin
                st_ff <= ST_IDLE;
            end
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (start) begin
                        st_ff  <= ST_SMP;
                        smp_ff <= 6'h00;
                    end
                end
                ST_SMP: begin
                    if (conv_tick) begin
                        if (smp_ff == smp_len) begin
                            st_ff  <= ST_CONV;
                            sar_ff <= 10'h200;
                            bit_ff <= 4'h9;
                        end else begin
                            smp_ff <= smp_ff + 6'h01;
                        end
                    end
                end
                ST_CONV: begin
                    // decide only once the comparator has seen the current trial
                    if (step) begin
                        // keep the trial bit while the input is above it
                        sar_ff[bit_ff] <= cmp_bit; // [R9]
                        if (bit_ff == 4'h0) begin
                            // continuous software mode loops, single idles
                            if (sc1_ff[asc_pkg::SC1_CONT] && !hw_mode) begin // [R11]
                                st_ff  <= ST_SMP;
                                smp_ff <= 6'h00;
                            end else begin
                                st_ff <= ST_IDLE;
                            end
                        end else begin
                            sar_ff[bit_ff - 4'h1] <= 1'b1;
                            bit_ff <= bit_ff - 4'h1;
                        end
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // ==================================================================
    // read port and outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                asc_pkg::OFF_SC1: rdata_ff <= {done_ff, sc1_ff[6:0]};
                asc_pkg::OFF_SC2: rdata_ff <= {st_ff != ST_IDLE, sc2_ff[6:0]};
                asc_pkg::OFF_RH:  rdata_ff <= {6'h00, res_ff[9:8]};
                asc_pkg::OFF_RL:  rdata_ff <= res_ff[7:0];
                asc_pkg::OFF_CVH: rdata_ff <= {6'h00, cv_ff[9:8]};
                asc_pkg::OFF_CVL: rdata_ff <= cv_ff[7:0];
                asc_pkg::OFF_CFG: rdata_ff <= cfg_ff;
                asc_pkg::OFF_APE: rdata_ff <= ape_ff;
                default:          rdata_ff <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_o               <= 1'b0;
            dac_o                  <= '0;
            channel_select_field_o <= asc_pkg::CH_OFF;
            analog_pin_enable_o    <= 8'h00;
            irq_o                  <= 1'b0;
            busy_o                 <= 1'b0;
        end else begin
            sample_o               <= (st_ff == ST_SMP);
            dac_o                  <= RES_W'(sar_ff);
            // the channel leaves through a register, so it lags the write a cycle
            channel_select_field_o <= sc1_ff[4:0]; // [R12]
            analog_pin_enable_o    <= ape_ff;
            irq_o                  <= done_ff && sc1_ff[asc_pkg::SC1_IEN]; // [R14]
            busy_o                 <= (st_ff != ST_IDLE);
        end
    end

    assign rdata_o = rdata_ff;

endmodule : asc_ctrl

// file: src/asc_pkg.sv
// Contract
// [R1] conversion clock: bus, bus half, local async
// [R2] alternate clock input absent, gives no clock
// [R3] hardware trigger starts conversion on counter overflow
// [R4] periodic counter clocked by reference or 32 kHz
// [R5] periodic counter free runs, rate-select sets period
// [R6] hardware trigger works in run, wait, stop3
// [R7] software sets stop-enable before stop3 operation
// [R8] only first pin enable register exists
// [R9] successive approximation resolves ten result bits
// [R10] right-justified result, 10-bit or 8-bit
// [R11] single or continuous; single returns to idle
// [R12] channel select field addresses 28 inputs
// [R13] optional compare: less-than or greater-or-equal flag
// [R14] completion flag with enableable interrupt request
// [R15] configurable sample time and speed/power
// [R16] software temperature sequence: long sample, AD27, AD26
// [R17] registers: two status, results, compares, config, pins
// [R18] status one write aborts, restarts unless channel ones; code restarts only while software triggering selected
// [R19] done flag clears on status write, result-low read
// [R20] overflows ignored while software triggering selected
package asc_pkg;

    // ==================================================================
    // register offsets
    localparam logic [2:0] OFF_SC1  = 3'h0;
    localparam logic [2:0] OFF_SC2  = 3'h1;
    localparam logic [2:0] OFF_RH   = 3'h2;
    localparam logic [2:0] OFF_RL   = 3'h3;
    localparam logic [2:0] OFF_CVH  = 3'h4;
    localparam logic [2:0] OFF_CVL  = 3'h5;
    localparam logic [2:0] OFF_CFG  = 3'h6;
    localparam logic [2:0] OFF_APE  = 3'h7;

    // ==================================================================
    // field positions
    localparam int SC1_DONE  = 7;
    localparam int SC1_IEN   = 6;
    localparam int SC1_CONT  = 5;
    localparam int SC2_ACT   = 7;
    localparam int SC2_HWTE  = 6;
    localparam int SC2_CMPE  = 5;
    localparam int SC2_CMPGT = 4;
    localparam int CFG_LPWR  = 7;
    localparam int CFG_DIVHI = 6;
    localparam int CFG_DIVLO = 5;
    localparam int CFG_LSMP  = 4;
    localparam int CFG_MODHI = 3;
    localparam int CFG_MODLO = 2;
    localparam int CFG_CLKHI = 1;
    localparam int CFG_CLKLO = 0;

    // ==================================================================
    // reset values and codes
    localparam logic [7:0] SC1_RST = 8'h1F;
    localparam logic [4:0] CH_OFF  = 5'h1F;
    localparam logic [1:0] CLK_BUS   = 2'h0;
    localparam logic [1:0] CLK_BUS2  = 2'h1;
    localparam logic [1:0] CLK_ALT   = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    localparam logic [1:0] MODE_8  = 2'h0;
    localparam logic [1:0] MODE_10 = 2'h2;

    // ==================================================================
    // cycle counts
    localparam int SMP_SHORT = 3;
    localparam int SMP_LONG  = 23;
    localparam int SMP_HSP   = 2;
    localparam int ASYNC_DIV = 4;
    localparam int SLOW_DIV  = 610;
    localparam logic [1:0] CMP_SETTLE = 2'h3;

endpackage : asc_pkg

// file: test/asc_afe_model.sv
`timescale 1ns/1ns
// ==========================================================
// analog source and periodic counter reference
module asc_afe_model (
    // clock
    input  wire logic       ref_clk_i,
    // analog side
    input  wire logic [9:0] dac_i,
    input  wire logic [9:0] level_i,
    output logic            cmp_o,
    // counter reference
    output logic            ref_tick_o
);
    // level sits half a step above its code, so ties cannot skew the result
    assign cmp_o = {level_i, 1'b1} > {dac_i, 1'b0};

    // software keeps the stop-enable bit set, so the reference never pauses
    initial ref_tick_o = 1'b0;

    // free-running reference at half the bus rate
    always @(posedge ref_clk_i) begin
        ref_tick_o <= ~ref_tick_o;
    end
endmodule : asc_afe_model

// file: test/asc_ctrl_checker.sv
`timescale 1ns/1ns
module asc_ctrl_checker (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    // register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // watched outputs
    input wire logic [4:0] channel_select_field_o,
    input wire logic       hw_conversion_trigger_o,
    input wire logic       sample_o,
    input wire logic       irq_o,
    input wire logic       busy_o
);
    // ==========================================================
    // helper state
    logic hwte_ff;
    logic sc1_wr;
    logic trg;

    assign sc1_wr = wr_i && (addr_i == asc_pkg::OFF_SC1);
    assign trg    = hw_conversion_trigger_o;

    // shadow of the trigger select, needed to tell the two start paths apart
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hwte_ff <= 1'b0;
        end else if (wr_i && (addr_i == asc_pkg::OFF_SC2)) begin
            hwte_ff <= wdata_i[asc_pkg::SC2_HWTE];
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_CH_FOLLOWS: assert property (sc1_wr |-> ##2
        channel_select_field_o == $past(wdata_i[4:0], 2)) else $error("channel not taken");
    AST_SW_START: assert property (sc1_wr && wdata_i[4:0] != asc_pkg::CH_OFF
        && !hwte_ff |-> ##[1:3] busy_o) else $error("write did not start");
    AST_OFF_STOP: assert property (sc1_wr && wdata_i[4:0] == asc_pkg::CH_OFF
        |-> ##2 !busy_o) else $error("disable did not stop");
    AST_CLR_WR: assert property (sc1_wr |-> ##2 !irq_o)
        else $error("done kept after write");
    AST_CLR_RD: assert property (rd_i && addr_i == asc_pkg::OFF_RL |-> ##2 !irq_o)
        else $error("done kept after low read");
    AST_RD_HOLD: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without read");
    AST_TRIG_PULSE: assert property (trg |=> !trg [*8])
        else $error("trigger not a lone pulse");
    AST_HW_START: assert property (hwte_ff && trg
        && channel_select_field_o != asc_pkg::CH_OFF |-> ##[1:3] busy_o)
        else $error("trigger did not start");
    AST_SW_IGNORE: assert property (!hwte_ff && trg && !busy_o && !wr_i
        && !$past(wr_i) |=> !busy_o) else $error("trigger started in software mode");
    AST_SAMPLE: assert property ($rose(busy_o) |-> ##[0:1] sample_o)
        else $error("no sampling phase");
endmodule : asc_ctrl_checker

// file: test/asc_ctrl_tb_top.sv
`timescale 1ns/1ns
module asc_ctrl_tb_top;
    localparam int LIM = 2000;
    logic       ref_clk;
    logic       rst_n;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       use_ref;
    logic [2:0] rate;
    logic [9:0] level;
    logic       cmp;
    logic       tick;
    logic [9:0] dac;
    logic [4:0] chan;
    logic [7:0] ape;
    logic       trig;
    logic       irq;
    logic       busy;
    logic [7:0] rdata;
    int         fails;
    int         checks_done;

    asc_ctrl i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .use_ref_clk_i(use_ref),
        .periodic_rate_select_i(rate), .ref_tick_i(tick), .cmp_i(cmp), .sample_o(),
        .dac_o(dac), .channel_select_field_o(chan), .analog_pin_enable_o(ape),
        .hw_conversion_trigger_o(trig), .irq_o(irq), .busy_o(busy));
    asc_afe_model i_afe (.ref_clk_i(ref_clk), .dac_i(dac), .level_i(level), .cmp_o(cmp),
        .ref_tick_o(tick));

    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask : rd_reg

    // skip the first cycles so a stale flag from before the start is not seen
    task automatic wait_irq(output int n);
        n = 0;
        repeat (3) @(negedge ref_clk);
        while (irq !== 1'b1 && n < LIM) begin
            @(negedge ref_clk);
            n++;
        end
    endtask : wait_irq

    task automatic conv(input logic [7:0] cfg, output int n);
        wr_reg(asc_pkg::OFF_CFG, cfg);
        wr_reg(asc_pkg::OFF_SC1, 8'h45);
        wait_irq(n);
    endtask : conv

    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] d;
        rd_reg(asc_pkg::OFF_SC1, d);
        chk(16'(d), 16'(asc_pkg::SC1_RST));
        chk(16'(chan), 16'h001F);
        wr_reg(asc_pkg::OFF_APE, 8'hA5);
        rd_reg(asc_pkg::OFF_APE, d);
        chk({d, ape}, 16'hA5A5);
    endtask : t_reset

    task automatic t_single();
        logic [7:0] h;
        logic [7:0] l;
        int         n;
        level <= 10'h2A4;
        conv(8'h08, n);
        chk(16'({n < LIM, chan}), 16'h0025);
        rd_reg(asc_pkg::OFF_RH, h);
        rd_reg(asc_pkg::OFF_RL, l);
        chk({h, l}, 16'h02A4);
        conv(8'h00, n);
        rd_reg(asc_pkg::OFF_RH, h);
        rd_reg(asc_pkg::OFF_RL, l);
        chk({h, l}, 16'h00A9);
        repeat (2) @(negedge ref_clk);
        chk(16'({irq, busy}), 16'h0000);
    endtask : t_single

    task automatic t_clocks();
        logic [7:0] cfg [4] = '{8'h08, 8'h09, 8'h0B, 8'h18};
        int         n [4];
        int         m;
        foreach (cfg[i]) conv(cfg[i], n[i]);
        chk(16'(n[0] < n[1] && n[1] < n[2] && n[2] < LIM), 16'h0001);
        chk(16'(n[3] > n[0] && n[3] < LIM), 16'h0001);
        conv(8'h0A, m);
        chk(16'(m == LIM), 16'h0001);
        wr_reg(asc_pkg::OFF_SC1, 8'h5F);
        repeat (3) @(negedge ref_clk);
        chk(16'({busy, chan}), 16'h001F);
    endtask : t_clocks

    task automatic t_compare();
        int n;
        wr_reg(asc_pkg::OFF_CVH, 8'h01);
        wr_reg(asc_pkg::OFF_CVL, 8'h00);
        wr_reg(asc_pkg::OFF_SC2, 8'h30);
        conv(8'h08, n);
        chk(16'(n < LIM), 16'h0001);
        wr_reg(asc_pkg::OFF_SC2, 8'h20);
        conv(8'h08, n);
        chk(16'(n == LIM), 16'h0001);
        wr_reg(asc_pkg::OFF_SC2, 8'h00);
    endtask : t_compare

    task automatic t_cont();
        logic [7:0] d;
        int         n;
        wr_reg(asc_pkg::OFF_SC1, 8'h65);
        wait_irq(n);
        rd_reg(asc_pkg::OFF_RL, d);
        wait_irq(n);
        chk(16'(n < LIM), 16'h0001);
        wr_reg(asc_pkg::OFF_SC1, 8'h1F);
        repeat (3) @(negedge ref_clk);
        chk(16'(busy), 16'h0000);
    endtask : t_cont

    task automatic t_hw();
        int m;
        int n;
        // live channel in software mode: only the trigger could start it here
        wr_reg(asc_pkg::OFF_SC2, 8'h40);
        wr_reg(asc_pkg::OFF_SC1, 8'h45);
        wr_reg(asc_pkg::OFF_SC2, 8'h00);
        @(posedge ref_clk);
        use_ref <= 1'b1;
        rate    <= 3'h1;
        m = 0;
        while (trig !== 1'b1 && m < LIM) begin
            @(negedge ref_clk);
            m++;
        end
        repeat (3) @(negedge ref_clk);
        chk(16'({m < LIM, busy}), 16'h0002);
        wr_reg(asc_pkg::OFF_SC2, 8'h40);
        wr_reg(asc_pkg::OFF_SC1, 8'h45);
        wait_irq(n);
        chk(16'(n < LIM), 16'h0001);
        wr_reg(asc_pkg::OFF_SC2, 8'h00);
        wr_reg(asc_pkg::OFF_SC1, 8'h1F);
    endtask : t_hw

    // long sample on the async clock divided by 8, bandgap channel first, then temperature
    task automatic t_temp();
        int n;
        wr_reg(asc_pkg::OFF_CFG, 8'h7B);
        wr_reg(asc_pkg::OFF_SC1, 8'h5B);
        wait_irq(n);
        chk(16'({n < LIM, chan}), 16'h003B);
        wr_reg(asc_pkg::OFF_SC1, 8'h5A);
        wait_irq(n);
        chk(16'({n < LIM, chan}), 16'h003A);
    endtask : t_temp

    // ==========================================================
    // run control
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        rst_n = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        use_ref = 1'b0;
        rate = 3'h0;
        level = 10'h000;
        fails = 0;
        checks_done = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_clocks();
        t_compare();
        t_cont();
        t_hw();
        t_temp();
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end
endmodule : asc_ctrl_tb_top

bind asc_ctrl asc_ctrl_checker i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .channel_select_field_o(channel_select_field_o), .sample_o(sample_o),
    .hw_conversion_trigger_o(hw_conversion_trigger_o), .irq_o(irq_o), .busy_o(busy_o));
